// ### rtl/cfi_defines.vh
`ifndef CFI_DEFINES_VH
`define CFI_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CFI_OFS_CTRL 8'h00
`define CFI_OFS_NETPROC 8'h04
`define CFI_OFS_INJ0 8'h08
`define CFI_OFS_INJ1 8'h0c
`define CFI_OFS_STATUS 8'h10
`define CFI_OFS_HDR_LO 8'h14
`define CFI_OFS_HDR_HI 8'h18
`define CFI_OFS_FRM_CNT 8'h1c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CFI_CTRL_PARSE0 0
`define CFI_CTRL_PARSE1 1
`define CFI_CTRL_PARSE_NP 2
`define CFI_CTRL_PREC 3
`define CFI_CTRL_XHDR 4
`define CFI_CTRL_RST 5'h00

// ----------------------------------------------------------------
// Network processor register fields
// ----------------------------------------------------------------
`define CFI_NP_PORT_LSB 0
`define CFI_NP_EN 5
`define CFI_NP_QSEL_LSB 8
`define CFI_NP_RST 16'h0000

// ----------------------------------------------------------------
// Injection word fields
// ----------------------------------------------------------------
`define CFI_INJ_LAST 8

// ----------------------------------------------------------------
// Injection header layout
// ----------------------------------------------------------------
`define CFI_HDR_BYTES 4'h8
`define CFI_HDR_SKIP 63
`define CFI_HDR_FWD_LSB 32
`define CFI_HDR_FWD_MSB 58
`define CFI_HDR_CPU_BIT 26
`define CFI_HDR_POP_LSB 28
`define CFI_HDR_QSEL_LSB 20
`define CFI_HDR_CLASS_LSB 17
`define CFI_HDR_TAGTYPE 16
`define CFI_HDR_PCP_LSB 13
`define CFI_HDR_DEI 12
`define CFI_HDR_VID_LSB 0
`define CFI_POP_NO_REWRITE 2'h3

// ----------------------------------------------------------------
// Port numbers
// ----------------------------------------------------------------
`define CFI_CPU_PORT_A 5'h1a
`define CFI_CPU_PORT_B 5'h1b

`endif

// ### rtl/cfi_top.v
`timescale 1ns/1ps
`include "cfi_defines.vh"

// ----------------------------------------------------------------
// Byte FIFO (depth must be a power of two)
// ----------------------------------------------------------------
module cfi_fifo #(
  parameter W = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Fill side
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  // Drain side
  output wire [W-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  localparam [AW:0] FULL = DEPTH;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem[rp_q];

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL);
      out_valid <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule // cfi_fifo

module cfi_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // Injection from the network processor port
  input wire [7:0] np_rx_data,
  input wire np_rx_valid,
  input wire np_rx_last,
  output wire np_rx_ready,
  // Frame stream into the switch core
  output reg [7:0] core_data_q,
  output reg core_valid_q,
  output reg core_last_q,
  input wire core_ready,
  // Per-frame descriptor, stable for the whole frame; the precedence enable follows CTRL bit 3 every cycle
  output reg [1:0] core_group_q,
  output reg [4:0] core_src_port_q,
  output reg core_skip_analysis_q,
  output reg [26:0] core_forward_port_mask_q,
  output reg [1:0] core_tag_pop_count_q,
  output reg core_rewrite_dis_q,
  output reg core_fcs_update_q,
  output reg [7:0] core_queue_mask_q,
  output reg [2:0] core_service_class_q,
  output reg core_tag_type_q,
  output reg [2:0] core_pcp_q,
  output reg core_dei_q,
  output reg [11:0] core_vid_q,
  output reg core_cpu_queue_precedence_en_q,
  // Extraction steering
  input wire ext_valid,
  input wire [7:0] ext_queue_mask,
  output reg ext_int_valid_q,
  output reg [7:0] ext_int_mask_q,
  output reg ext_np_valid_q,
  output reg [7:0] ext_np_mask_q,
  output reg [4:0] netproc_port_number_q,
  output reg netproc_port_en_q,
  output reg extract_header_prepend_en_q
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_HDR = 2'h1;
  localparam [1:0] ST_BODY = 2'h2;
  localparam [1:0] ST_DROP = 2'h3;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [4:0] ctrl_q;
  reg [15:0] np_cfg_q;
  reg drop0_q;
  reg drop1_q;
  reg hdr_err_q;
  reg [15:0] frm_cnt_q;
  reg [1:0] st_q;
  reg [1:0] sel_q;
  reg [3:0] hcnt_q;
  reg [63:0] hdr_q;
  reg [63:0] hdr_last_q;

  wire inj0_wr = reg_wr && (reg_addr == `CFI_OFS_INJ0);
  wire inj1_wr = reg_wr && (reg_addr == `CFI_OFS_INJ1);

  // ----------------------------------------------------------------
  // Source FIFOs: group A, group B, network processor port
  // ----------------------------------------------------------------
  wire [8:0] f0_data;
  wire [8:0] f1_data;
  wire [8:0] f2_data;
  wire f0_valid;
  wire f1_valid;
  wire f2_valid;
  wire f0_in_ready;
  wire f1_in_ready;
  wire f2_in_ready;
  wire pop;

  cfi_fifo #(.W(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo0 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data(reg_wdata[8:0]),
    .in_valid(inj0_wr),
    .in_ready(f0_in_ready),
    .out_data(f0_data),
    .out_valid(f0_valid),
    .out_ready(pop && (sel_q == 2'h0))
  );

  cfi_fifo #(.W(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo1 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data(reg_wdata[8:0]),
    .in_valid(inj1_wr),
    .in_ready(f1_in_ready),
    .out_data(f1_data),
    .out_valid(f1_valid),
    .out_ready(pop && (sel_q == 2'h1))
  );

  cfi_fifo #(.W(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo2 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data({np_rx_last, np_rx_data}),
    .in_valid(np_rx_valid),
    .in_ready(f2_in_ready),
    .out_data(f2_data),
    .out_valid(f2_valid),
    .out_ready(pop && (sel_q == 2'h2))
  );

  assign np_rx_ready = f2_in_ready;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  reg [8:0] s_data;
  reg s_valid;
  reg s_parse;

  always @* begin
    case (sel_q)
      2'h0: begin
        s_data = f0_data;
        s_valid = f0_valid;
        s_parse = ctrl_q[`CFI_CTRL_PARSE0];
      end
      2'h1: begin
        s_data = f1_data;
        s_valid = f1_valid;
        s_parse = ctrl_q[`CFI_CTRL_PARSE1];
      end
      2'h2: begin
        s_data = f2_data;
        s_valid = f2_valid;
        s_parse = ctrl_q[`CFI_CTRL_PARSE_NP];
      end
      default: begin
        s_data = 9'h000;
        s_valid = 1'b0;
        s_parse = 1'b0;
      end
    endcase
  end

  // Round robin over the three sources, starting after the last one served
  function [1:0] cfi_next_src;
    input [1:0] last;
    input [2:0] req;
    begin
      case (last)
        2'h0: cfi_next_src = req[1] ? 2'h1 : (req[2] ? 2'h2 : 2'h0);
        2'h1: cfi_next_src = req[2] ? 2'h2 : (req[0] ? 2'h0 : 2'h1);
        default: cfi_next_src = req[0] ? 2'h0 : (req[1] ? 2'h1 : 2'h2);
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Frame parser and output stage
  // ----------------------------------------------------------------
  wire out_free = !core_valid_q || core_ready;
  wire s_last = s_data[`CFI_INJ_LAST];
  // Header state only consumes bytes while parsing; otherwise the first byte waits for the body state
  assign pop = s_valid && (((st_q == ST_HDR) && s_parse) || (st_q == ST_DROP) || ((st_q == ST_BODY) && out_free));
  wire [63:0] hdr_d = {hdr_q[55:0], s_data[7:0]};
  wire hdr_done = pop && (st_q == ST_HDR) && (hcnt_q == `CFI_HDR_BYTES - 4'h1);
  wire hdr_skip = hdr_d[`CFI_HDR_SKIP];

  always @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      sel_q <= 2'h2;
      hcnt_q <= 4'h0;
      hdr_q <= 64'h0;
      hdr_last_q <= 64'h0;
      hdr_err_q <= 1'b0;
      frm_cnt_q <= 16'h0000;
      core_data_q <= 8'h00;
      core_valid_q <= 1'b0;
      core_last_q <= 1'b0;
      core_group_q <= 2'h0;
      core_src_port_q <= `CFI_CPU_PORT_A;
      core_skip_analysis_q <= 1'b0;
      core_forward_port_mask_q <= 27'h0000000;
      core_tag_pop_count_q <= 2'h0;
      core_rewrite_dis_q <= 1'b0;
      core_fcs_update_q <= 1'b0;
      core_queue_mask_q <= 8'h00;
      core_service_class_q <= 3'h0;
      core_tag_type_q <= 1'b0;
      core_pcp_q <= 3'h0;
      core_dei_q <= 1'b0;
      core_vid_q <= 12'h000;
    end else begin
      if (core_valid_q && core_ready) begin
        core_valid_q <= 1'b0;
      end
      // Header error: clear by write-one, a new error in the same cycle wins
      if (reg_wr && (reg_addr == `CFI_OFS_STATUS) && reg_wdata[2]) begin
        hdr_err_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          // Wait for the previous last byte to leave so the descriptor never moves under it
          if ((f0_valid || f1_valid || f2_valid) && !core_valid_q) begin
            sel_q <= cfi_next_src(sel_q, {f2_valid, f1_valid, f0_valid});
            st_q <= ST_HDR;
            hcnt_q <= 4'h0;
          end
        end
        ST_HDR: begin
          if (!s_parse) begin
            // No header expected: analyzer decides everything
            core_group_q <= sel_q;
            core_src_port_q <= `CFI_CPU_PORT_A;
            core_skip_analysis_q <= 1'b0;
            core_forward_port_mask_q <= 27'h0000000;
            core_tag_pop_count_q <= 2'h0;
            core_rewrite_dis_q <= 1'b0;
            core_fcs_update_q <= 1'b1;
            core_queue_mask_q <= 8'h00;
            core_service_class_q <= 3'h0;
            core_tag_type_q <= 1'b0;
            core_pcp_q <= 3'h0;
            core_dei_q <= 1'b0;
            core_vid_q <= 12'h000;
            st_q <= ST_BODY;
          end else if (pop) begin
            hdr_q <= hdr_d;
            hcnt_q <= hcnt_q + 4'h1;
            if (s_last) begin
              // Frame no longer than its header is discarded
              hdr_err_q <= 1'b1;
              st_q <= ST_IDLE;
            end else if (hdr_done) begin
              hdr_last_q <= hdr_d;
              core_group_q <= sel_q;
              core_src_port_q <= `CFI_CPU_PORT_A;
              core_skip_analysis_q <= hdr_skip;
              core_fcs_update_q <= 1'b1;
              if (hdr_skip) begin
                core_forward_port_mask_q <= hdr_d[`CFI_HDR_FWD_MSB:`CFI_HDR_FWD_LSB];
                core_tag_pop_count_q <= hdr_d[`CFI_HDR_POP_LSB+1:`CFI_HDR_POP_LSB];
                core_rewrite_dis_q <=
                  (hdr_d[`CFI_HDR_POP_LSB+1:`CFI_HDR_POP_LSB] == `CFI_POP_NO_REWRITE);
                core_queue_mask_q <= hdr_d[`CFI_HDR_FWD_LSB+`CFI_HDR_CPU_BIT] ?
                  hdr_d[`CFI_HDR_QSEL_LSB+7:`CFI_HDR_QSEL_LSB] : 8'h00;
                core_service_class_q <= hdr_d[`CFI_HDR_CLASS_LSB+2:`CFI_HDR_CLASS_LSB];
                core_tag_type_q <= hdr_d[`CFI_HDR_TAGTYPE];
                core_pcp_q <= hdr_d[`CFI_HDR_PCP_LSB+2:`CFI_HDR_PCP_LSB];
                core_dei_q <= hdr_d[`CFI_HDR_DEI];
                core_vid_q <= hdr_d[`CFI_HDR_VID_LSB+11:`CFI_HDR_VID_LSB];
              end else begin
                core_forward_port_mask_q <= 27'h0000000;
                core_tag_pop_count_q <= 2'h0;
                core_rewrite_dis_q <= 1'b0;
                core_queue_mask_q <= 8'h00;
                core_service_class_q <= 3'h0;
                core_tag_type_q <= 1'b0;
                core_pcp_q <= 3'h0;
                core_dei_q <= 1'b0;
                core_vid_q <= 12'h000;
              end
              st_q <= ST_BODY;
            end
          end
        end
        ST_BODY: begin
          if (pop) begin
            core_data_q <= s_data[7:0];
            core_last_q <= s_last;
            core_valid_q <= 1'b1;
            if (s_last) begin
              frm_cnt_q <= frm_cnt_q + 16'h0001;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_DROP: begin
          if (pop && s_last) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q <= `CFI_CTRL_RST;
      np_cfg_q <= `CFI_NP_RST;
      drop0_q <= 1'b0;
      drop1_q <= 1'b0;
      reg_rdata_q <= 32'h00000000;
    end else begin
      if (reg_wr && (reg_addr == `CFI_OFS_CTRL)) begin
        ctrl_q <= reg_wdata[4:0];
      end
      if (reg_wr && (reg_addr == `CFI_OFS_NETPROC)) begin
        np_cfg_q <= {reg_wdata[15:8], 2'h0, reg_wdata[5:0]};
      end
      // Drop flags: a write to a full group sets, write-one clears, set wins
      if (reg_wr && (reg_addr == `CFI_OFS_STATUS) && reg_wdata[0]) begin
        drop0_q <= 1'b0;
      end
      if (reg_wr && (reg_addr == `CFI_OFS_STATUS) && reg_wdata[1]) begin
        drop1_q <= 1'b0;
      end
      if (inj0_wr && !f0_in_ready) begin
        drop0_q <= 1'b1;
      end
      if (inj1_wr && !f1_in_ready) begin
        drop1_q <= 1'b1;
      end
      reg_rdata_q <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `CFI_OFS_CTRL: reg_rdata_q <= {27'h0000000, ctrl_q};
          `CFI_OFS_NETPROC: reg_rdata_q <= {16'h0000, np_cfg_q};
          `CFI_OFS_STATUS: reg_rdata_q <= {22'h000000, st_q, 1'b0,
            f2_in_ready, f1_in_ready, f0_in_ready, 1'b0, hdr_err_q, drop1_q, drop0_q};
          `CFI_OFS_HDR_LO: reg_rdata_q <= hdr_last_q[31:0];
          `CFI_OFS_HDR_HI: reg_rdata_q <= hdr_last_q[63:32];
          `CFI_OFS_FRM_CNT: reg_rdata_q <= {16'h0000, frm_cnt_q};
          default: reg_rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs and extraction steering
  // ----------------------------------------------------------------
  wire [7:0] qsel = np_cfg_q[`CFI_NP_QSEL_LSB+7:`CFI_NP_QSEL_LSB];
  wire [7:0] q_np = ext_queue_mask & qsel & {8{np_cfg_q[`CFI_NP_EN]}};
  wire [7:0] q_int = ext_queue_mask & ~q_np;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      core_cpu_queue_precedence_en_q <= 1'b0;
      netproc_port_number_q <= 5'h00;
      netproc_port_en_q <= 1'b0;
      extract_header_prepend_en_q <= 1'b0;
      ext_int_valid_q <= 1'b0;
      ext_int_mask_q <= 8'h00;
      ext_np_valid_q <= 1'b0;
      ext_np_mask_q <= 8'h00;
    end else begin
      core_cpu_queue_precedence_en_q <= ctrl_q[`CFI_CTRL_PREC];
      netproc_port_number_q <= np_cfg_q[`CFI_NP_PORT_LSB+4:`CFI_NP_PORT_LSB];
      netproc_port_en_q <= np_cfg_q[`CFI_NP_EN];
      extract_header_prepend_en_q <= ctrl_q[`CFI_CTRL_XHDR];
      // Both copies go out when queues land on both sides
      ext_int_valid_q <= ext_valid && (q_int != 8'h00);
      ext_int_mask_q <= ext_valid ? q_int : 8'h00;
      ext_np_valid_q <= ext_valid && (q_np != 8'h00);
      ext_np_mask_q <= ext_valid ? q_np : 8'h00;
    end
  end
endmodule // cfi_top

// ### tb/cfi_np_model.sv
`timescale 1ns/1ps
module cfi_np_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Byte stream into the block
  input wire logic np_rx_ready,
  output logic [7:0] np_rx_data = 8'h00,
  output logic np_rx_valid = 1'b0,
  output logic np_rx_last = 1'b0
);
  logic [8:0] q[$];
  task automatic push(input logic [8:0] b);
    q.push_back(b);
  endtask
  // Byte held until taken; idle gaps at random; idle data toggles
  always @(posedge clk_sys) begin
    if (!rstn) begin
      np_rx_valid <= 1'b0;
    end else if (!np_rx_valid || np_rx_ready) begin
      if (np_rx_valid) void'(q.pop_front());
      if (q.size() > 0 && $urandom % 4 != 0) begin
        np_rx_valid <= 1'b1;
        {np_rx_last, np_rx_data} <= q[0];
      end else begin
        np_rx_valid <= 1'b0;
        np_rx_data <= ~np_rx_data;
      end
    end
  end
endmodule // cfi_np_model

// ### tb/cfi_top_monitor.sv
`timescale 1ns/1ps
module cfi_top_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Core stream
  input wire logic core_ready,
  input wire logic core_valid_q,
  input wire logic [7:0] core_data_q,
  input wire logic [4:0] core_src_port_q,
  input wire logic core_skip_analysis_q,
  input wire logic [26:0] core_forward_port_mask_q,
  input wire logic [1:0] core_tag_pop_count_q,
  input wire logic core_rewrite_dis_q,
  input wire logic [7:0] core_queue_mask_q,
  input wire logic core_cpu_queue_precedence_en_q,
  // Extraction
  input wire logic ext_valid,
  input wire logic [7:0] ext_queue_mask,
  input wire logic ext_int_valid_q,
  input wire logic [7:0] ext_int_mask_q,
  input wire logic ext_np_valid_q,
  input wire logic [7:0] ext_np_mask_q,
  input wire logic [4:0] netproc_port_number_q,
  input wire logic netproc_port_en_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_src; core_src_port_q == 5'h1a; endproperty
  a_src: assert property (p_src) else $error("source port is not 26");
  property p_hold; core_valid_q && !core_ready |=> core_valid_q && $stable(core_data_q)
    && $stable(core_forward_port_mask_q); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte or descriptor moved");
  property p_rwd; core_valid_q |-> core_rewrite_dis_q == (core_tag_pop_count_q == 2'h3); endproperty
  a_rwd: assert property (p_rwd) else $error("rewrite disable wrong");
  property p_qm; core_valid_q && core_queue_mask_q != 8'h00 |->
    core_skip_analysis_q && core_forward_port_mask_q[26]; endproperty
  a_qm: assert property (p_qm) else $error("queue mask without bypass to cpu");
  property p_nosk; core_valid_q && !core_skip_analysis_q |-> core_forward_port_mask_q == 27'h0; endproperty
  a_nosk: assert property (p_nosk) else $error("mask used without bypass");
  property p_split; ext_valid |=> (ext_int_mask_q | ext_np_mask_q) == $past(ext_queue_mask)
    && (ext_int_mask_q & ext_np_mask_q) == 8'h00; endproperty
  a_split: assert property (p_split) else $error("extraction split wrong");
  property p_npoff; ext_valid && !netproc_port_en_q |=> !ext_np_valid_q; endproperty
  a_npoff: assert property (p_npoff) else $error("external copy while disabled");
  property p_both; ext_int_mask_q != 8'h00 && ext_np_mask_q != 8'h00 |->
    ext_int_valid_q && ext_np_valid_q; endproperty
  a_both: assert property (p_both) else $error("copy missing on one side");
  property p_prec; reg_wr && reg_addr == 8'h00 |=> ##1
    core_cpu_queue_precedence_en_q == $past(reg_wdata[3], 2); endproperty
  a_prec: assert property (p_prec) else $error("precedence copy wrong");
  property p_np; reg_wr && reg_addr == 8'h04 |=> ##1 netproc_port_number_q == $past(reg_wdata[4:0], 2)
    && netproc_port_en_q == $past(reg_wdata[5], 2); endproperty
  a_np: assert property (p_np) else $error("network processor port copy wrong");
  c_bypass: cover property (core_valid_q && core_ready && core_skip_analysis_q);
  c_nowr: cover property (core_valid_q && core_rewrite_dis_q);
  c_both: cover property (ext_int_valid_q && ext_np_valid_q);
endmodule // cfi_top_monitor

bind cfi_top cfi_top_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .core_ready(core_ready), .core_valid_q(core_valid_q),
  .core_data_q(core_data_q), .core_src_port_q(core_src_port_q), .core_skip_analysis_q(core_skip_analysis_q),
  .core_forward_port_mask_q(core_forward_port_mask_q), .core_tag_pop_count_q(core_tag_pop_count_q),
  .core_rewrite_dis_q(core_rewrite_dis_q), .core_queue_mask_q(core_queue_mask_q),
  .core_cpu_queue_precedence_en_q(core_cpu_queue_precedence_en_q), .ext_valid(ext_valid),
  .ext_queue_mask(ext_queue_mask), .ext_int_valid_q(ext_int_valid_q), .ext_int_mask_q(ext_int_mask_q),
  .ext_np_valid_q(ext_np_valid_q), .ext_np_mask_q(ext_np_mask_q),
  .netproc_port_number_q(netproc_port_number_q), .netproc_port_en_q(netproc_port_en_q));

// ### tb/tb_cpu_frame_injection_npi.sv
`timescale 1ns/1ps
module tb_cpu_frame_injection_npi;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, core_ready = 1'b0, ext_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, ext_queue_mask = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  wire [31:0] reg_rdata_q;
  wire [7:0] np_rx_data, core_data_q, core_queue_mask_q, ext_int_mask_q, ext_np_mask_q;
  wire np_rx_valid, np_rx_last, np_rx_ready, core_valid_q, core_last_q, core_skip_analysis_q;
  wire core_rewrite_dis_q, core_fcs_update_q, core_tag_type_q, core_dei_q, core_cpu_queue_precedence_en_q;
  wire ext_int_valid_q, ext_np_valid_q, netproc_port_en_q, extract_header_prepend_en_q;
  wire [1:0] core_group_q, core_tag_pop_count_q;
  wire [4:0] core_src_port_q, netproc_port_number_q;
  wire [26:0] core_forward_port_mask_q;
  wire [2:0] core_service_class_q, core_pcp_q;
  wire [11:0] core_vid_q;
  int mismatches = 0, checks = 0;
  logic rdy_mode = 1'b1, first = 1'b1;
  logic [8:0] got[$];
  logic [61:0] gdesc;
  always #50 clk_sys = ~clk_sys;
  cfi_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .np_rx_data(np_rx_data),
    .np_rx_valid(np_rx_valid), .np_rx_last(np_rx_last), .np_rx_ready(np_rx_ready),
    .core_data_q(core_data_q), .core_valid_q(core_valid_q), .core_last_q(core_last_q),
    .core_ready(core_ready), .core_group_q(core_group_q), .core_src_port_q(core_src_port_q),
    .core_skip_analysis_q(core_skip_analysis_q), .core_forward_port_mask_q(core_forward_port_mask_q),
    .core_tag_pop_count_q(core_tag_pop_count_q), .core_rewrite_dis_q(core_rewrite_dis_q),
    .core_fcs_update_q(core_fcs_update_q), .core_queue_mask_q(core_queue_mask_q),
    .core_service_class_q(core_service_class_q), .core_tag_type_q(core_tag_type_q),
    .core_pcp_q(core_pcp_q), .core_dei_q(core_dei_q), .core_vid_q(core_vid_q),
    .core_cpu_queue_precedence_en_q(core_cpu_queue_precedence_en_q), .ext_valid(ext_valid),
    .ext_queue_mask(ext_queue_mask), .ext_int_valid_q(ext_int_valid_q), .ext_int_mask_q(ext_int_mask_q),
    .ext_np_valid_q(ext_np_valid_q), .ext_np_mask_q(ext_np_mask_q),
    .netproc_port_number_q(netproc_port_number_q), .netproc_port_en_q(netproc_port_en_q),
    .extract_header_prepend_en_q(extract_header_prepend_en_q));
  cfi_np_model u_np (.clk_sys(clk_sys), .rstn(rstn), .np_rx_ready(np_rx_ready),
    .np_rx_data(np_rx_data), .np_rx_valid(np_rx_valid), .np_rx_last(np_rx_last));
  // ----------------------------------------------------------------
  // Core side: random stalls, byte and descriptor capture
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    core_ready <= rdy_mode & ($urandom % 4 != 0);
    if (core_valid_q && core_ready) begin
      if (first) gdesc <= {core_group_q, core_skip_analysis_q, core_forward_port_mask_q, core_tag_pop_count_q,
        core_rewrite_dis_q, core_fcs_update_q, core_queue_mask_q, core_service_class_q, core_tag_type_q,
        core_pcp_q, core_dei_q, core_vid_q};
      got.push_back({core_last_q, core_data_q});
      first <= core_last_q;
    end
  end
  function automatic logic [61:0] exp_desc(input logic [63:0] h, input logic [1:0] g, input logic p);
    if (!(p && h[63])) return {g, 31'h0, 1'b1, 28'h0};
    return {g, 1'b1, h[58:32], h[29:28], h[29:28] == 2'h3, 1'b1, h[58] ? h[27:20] : 8'h00, h[19:0]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
    @(posedge clk_sys);
  endtask
  task automatic run_frame(input logic [1:0] g, input logic p, input logic [63:0] h, input int n);
    logic [7:0] b[$];
    int k, w;
    got = {};
    if (p) for (k = 7; k >= 0; k--) b.push_back(h[8*k +: 8]);
    for (k = 0; k < n; k++) b.push_back(8'($urandom));
    for (k = 0; k < b.size(); k++) begin
      if (g == 2'h2) u_np.push({k == b.size() - 1, b[k]});
      else wr(g[0] ? 8'h0c : 8'h08, {23'h0, k == b.size() - 1, b[k]});
    end
    w = 0;
    while (got.size() < n && w < 3000) begin
      @(posedge clk_sys);
      #1 w++;
    end
    @(posedge clk_sys);
    chk(64'(got.size()), 64'(n));
    for (k = 0; k < n && k < got.size(); k++) chk(got[k], {k == n - 1, b[k + (p ? 8 : 0)]});
    chk(gdesc, exp_desc(h, g, p));
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    mismatches++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [63:0] h;
    logic [7:0] e;
    logic p;
    int i;
    void'($urandom(32'h696e));
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1 chk({np_rx_ready, core_valid_q, core_src_port_q}, {2'b10, 5'h1a});
    @(posedge clk_sys);
    rd(8'h20, v);
    chk(v, 32'h0);
    rd(8'h04, v);
    chk(v, 32'h0);
    $display("test reset_regs done");
    wr(8'h04, 32'h21);
    for (i = 0; i < 12; i++) begin
      h = {$urandom, $urandom};
      h[63] = i[0] | (i > 7);
      h[29:28] = i[1:0];
      p = (i != 0) && (i != 4);
      v = ($urandom & 32'h18) | {29'h0, p, p, p};
      wr(8'h00, v);
      run_frame(2'(i % 3), p, h, 1 + $urandom % 6);
      chk({core_cpu_queue_precedence_en_q, extract_header_prepend_en_q}, {v[3], v[4]});
    end
    $display("test frames done");
    wr(8'h00, 32'h2);
    got = {};
    wr(8'h0c, 32'haa);
    wr(8'h0c, 32'h1cc);
    v = 32'h0;
    for (i = 0; i < 20 && !v[2]; i++) rd(8'h10, v);
    chk({got.size() == 0, v[2]}, 2'b11);
    wr(8'h10, 32'h4);
    $display("test header_error done");
    rdy_mode <= 1'b0;
    wr(8'h00, 32'h0);
    for (i = 0; i < 24; i++) wr(8'h08, i);
    rd(8'h10, v);
    chk(v & 32'h17, 32'h1);
    rdy_mode <= 1'b1;
    wr(8'h10, 32'h1);
    rd(8'h10, v);
    chk(v & 32'h1, 32'h0);
    wr(8'h08, 32'h100);
    for (i = 0; i < 200 && !(got.size() > 0 && got[$][8]); i++) @(posedge clk_sys);
    chk(got[$][8], 1'b1);
    chk(64'(got.size()), 64'd18);
    $display("test fifo_full done");
    for (i = 0; i < 16; i++) begin
      v = $urandom & (i == 0 ? 32'hff1f : 32'hff3f);
      wr(8'h04, v);
      e = v[15:8] & {8{v[5]}};
      ext_queue_mask <= i == 1 ? 8'hff : 8'($urandom);
      ext_valid <= 1'b1;
      @(posedge clk_sys);
      ext_valid <= 1'b0;
      #1 chk({ext_int_valid_q, ext_np_valid_q, ext_int_mask_q, ext_np_mask_q},
        {(ext_queue_mask & ~e) != 8'h00, (ext_queue_mask & e) != 8'h00, ext_queue_mask & ~e, ext_queue_mask & e});
      chk({netproc_port_en_q, netproc_port_number_q}, v[5:0]);
      @(posedge clk_sys);
    end
    $display("test extraction done");
    print_verdict;
  end
endmodule // tb_cpu_frame_injection_npi
